// ---- hw/pdc_consts.svh ----
// constants of the pin-controlled power-down block
// assumes the 25 MHz core clock; included by the package only
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

`define PDC_NUM_MC        32
`define PDC_DOWN_MC       5'h2
`define PDC_CLK_NS        40
`define PDC_T_VALID_NS    7
`define PDC_T_IGNORE_NS   12
`define PDC_T_RESUME_NS   1000
`define PDC_IGNORE_CYC    (((`PDC_T_IGNORE_NS + `PDC_CLK_NS - 1) / `PDC_CLK_NS) > 0 ? ((`PDC_T_IGNORE_NS + `PDC_CLK_NS - 1) / `PDC_CLK_NS) : 1)
`define PDC_RESUME_CYC    ((`PDC_T_RESUME_NS / `PDC_CLK_NS) > 0 ? (`PDC_T_RESUME_NS / `PDC_CLK_NS) : 1)
`define PDC_CNT_W         6
`define PDC_RST_WORD      32'h0000_0000

`endif

// ---- hw/pdc_input_keeper.sv ----
// input and I/O hold latches in front of the logic array
// assumes pad levels synchronous to clk; block comes from the controller
`timescale 1ns/100ps

module pdc_input_keeper import pdc_pkg::*; (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         clkEn,
	input  wire logic         block,
	input  wire logic         maskDownPin,
	input  wire pdc_word_type pinIn,
	output pdc_word_type      keptIn
);

	pdc_keep_state_type state_ff;
	pdc_keep_state_type nxt_state;
	pdc_word_type       nxt_held;

	genvar i;
	generate
		for (i = 0; i < `PDC_NUM_MC; i++) begin : g_keep
			// power-down pin never reaches the array while the option owns it
			localparam logic [4:0] IDX = 5'(i);
			always_comb begin
				if (block)
					nxt_held[i] = state_ff.held[i]; // R5 R6
				else if (maskDownPin && IDX == `PDC_DOWN_MC)
					nxt_held[i] = 1'b0; // R7
				else
					nxt_held[i] = pinIn[i]; // R1 R11
			end
		end
	endgenerate

	always_comb begin
		nxt_state      = state_ff;
		nxt_state.held = nxt_held;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			state_ff <= '{held: `PDC_RST_WORD};
		else if (clkEn)
			state_ff <= nxt_state;
	end

	assign keptIn = state_ff.held;

endmodule : pdc_input_keeper

// ---- hw/pdc_macrocell_bank.sv ----
// macrocell registers and output drivers with freeze support
// assumes array terms synchronous to clk; freeze from the controller
`timescale 1ns/100ps

module pdc_macrocell_bank import pdc_pkg::*; (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          clkEn,
	input  wire logic          freeze,
	input  wire logic          downPinIsInput,
	input  wire pdc_array_type term,
	output pdc_word_type       feedback,
	output pdc_pad_type        pad
);

	pdc_bank_state_type state_ff;
	pdc_bank_state_type nxt_state;
	pdc_word_type       nxtQ;
	pdc_word_type       nxtData;
	pdc_word_type       nxtOe;

	genvar i;
	generate
		for (i = 0; i < `PDC_NUM_MC; i++) begin : g_mc
			localparam logic [4:0] IDX = 5'(i);
			always_comb begin
				if (freeze) begin
					// clocks and enables are ignored, so everything holds
					nxtQ[i]    = state_ff.q[i]; // R3 R5
					nxtData[i] = state_ff.pad.data[i]; // R3
					nxtOe[i]   = state_ff.pad.oe[i]; // R4
				end else begin
					// buried feedback of the power-down macrocell stays usable
					nxtQ[i]    = term.regEn[i] ? term.d[i] : state_ff.q[i]; // R8 R13
					nxtData[i] = term.comSel[i] ? term.d[i] : nxtQ[i]; // R12
					nxtOe[i]   = term.oe[i] &&
						!(downPinIsInput && IDX == `PDC_DOWN_MC); // R1
				end
			end
		end
	endgenerate

	always_comb begin
		nxt_state          = state_ff;
		nxt_state.q        = nxtQ;
		nxt_state.pad.data = nxtData;
		nxt_state.pad.oe   = nxtOe;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			state_ff <= '{q: `PDC_RST_WORD,
				pad: '{data: `PDC_RST_WORD, oe: `PDC_RST_WORD}};
		else if (clkEn)
			state_ff <= nxt_state;
	end

	assign feedback = state_ff.q;
	assign pad      = state_ff.pad;

endmodule : pdc_macrocell_bank

// ---- hw/pdc_pkg.sv ----
// types of the pin-controlled power-down block
// assumes pdc_consts.svh on the include path
`include "pdc_consts.svh"

package pdc_pkg;

	typedef logic [`PDC_NUM_MC-1:0] pdc_word_type;

	typedef enum logic [1:0] {
		PDC_ACTIVE,
		PDC_SETTLING,
		PDC_FROZEN,
		PDC_RESUMING
	} pdc_mode_type;

	// product-term side of the macrocells, as the array presents it
	typedef struct packed {
		pdc_word_type d;
		pdc_word_type oe;
		pdc_word_type regEn;
		pdc_word_type comSel;
	} pdc_array_type;

	typedef struct packed {
		pdc_word_type data;
		pdc_word_type oe;
	} pdc_pad_type;

	typedef struct packed {
		pdc_word_type held;
	} pdc_keep_state_type;

	typedef struct packed {
		pdc_word_type q;
		pdc_pad_type  pad;
	} pdc_bank_state_type;

	typedef struct packed {
		pdc_mode_type                mode;
		logic [`PDC_CNT_W-1:0]       cnt;
		logic                        lowPower;
		logic                        running;
		logic                        arrayDownIn;
	} pdc_ctrl_state_type;

endpackage : pdc_pkg

// ---- hw/pdc_power_down_ctrl.sv ----
// top of the pin-controlled power-down block: sequencer, keeper, bank
// assumes all pads sampled synchronously to the 25 MHz clk
//
// Behaviour
// [R1] power-down is an option; without it the power-down pin is plain I/O.
// [R2] with the option on, a high power-down pin freezes the device while high.
// [R3] entering the frozen state captures and holds every register and output.
// [R4] an output in high-impedance when power-down starts stays so throughout.
// [R5] while frozen every input, clock and enable is ignored but power-down.
// [R6] while frozen the input hold latches keep every pin at its last level.
// [R7] with the option on, the power-down pin never feeds the logic array.
// [R8] the power-down macrocell keeps its buried feedback and foldback terms.
// [R9] the driver holds inputs, enables, clocks valid 7 ns before the pin rises.
// [R10] inputs stay unchanged until 12 ns after the pin rises, then are ignored.
// [R11] after the pin falls, inputs, enables and clocks are taken within 1 us.
// [R12] after the pin falls the outputs show normal operation within 1 us.
// [R13] leaving the frozen state resumes from the held states with no reinitialisation.
`timescale 1ns/100ps

module pdc_power_down_ctrl import pdc_pkg::*; (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          clkEn,
	input  wire logic          powerDownEn,
	input  wire logic          powerDownPin,
	input  wire pdc_word_type  pinIn,
	input  wire pdc_array_type term,
	output pdc_word_type       arrayIn,
	output pdc_word_type       feedback,
	output pdc_pad_type        pad,
	output logic               arrayDownIn,
	output logic               lowPower,
	output logic               running
);

	localparam logic [`PDC_CNT_W-1:0] IGNORE_LAST =
		`PDC_CNT_W'(`PDC_IGNORE_CYC - 1);
	localparam logic [`PDC_CNT_W-1:0] RESUME_LAST =
		`PDC_CNT_W'(`PDC_RESUME_CYC - 1);

	pdc_ctrl_state_type state_ff;
	pdc_ctrl_state_type nxt_state;
	logic               frozen;
	logic               downRequest;

	// the pin only means power-down when the option is configured
	assign downRequest = powerDownEn && powerDownPin; // R1 R2
	assign frozen      = (state_ff.mode == PDC_FROZEN); // R5

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff.mode)
			PDC_ACTIVE: begin
				nxt_state.cnt = '0;
				if (downRequest) begin
					// inputs are still taken while the driver holds them stable
					nxt_state.mode    = PDC_SETTLING; // R10
					nxt_state.running = 1'b0;
				end
			end
			PDC_SETTLING: begin
				if (!downRequest) begin
					nxt_state.mode = PDC_RESUMING;
					nxt_state.cnt  = '0;
				end else if (state_ff.cnt == IGNORE_LAST) begin
					nxt_state.mode     = PDC_FROZEN; // R2 R10
					nxt_state.lowPower = 1'b1;
					nxt_state.cnt      = '0;
				end else begin
					nxt_state.cnt = state_ff.cnt + 1'b1;
				end
			end
			PDC_FROZEN: begin
				if (!downRequest) begin
					// inputs reopen at once; held state carries on
					nxt_state.mode     = PDC_RESUMING; // R11 R13
					nxt_state.lowPower = 1'b0;
					nxt_state.cnt      = '0;
				end
			end
			PDC_RESUMING: begin
				if (downRequest) begin
					nxt_state.mode = PDC_SETTLING;
					nxt_state.cnt  = '0;
				end else if (state_ff.cnt == RESUME_LAST) begin
					// running marks the end of the worst-case recovery
					nxt_state.mode    = PDC_ACTIVE; // R12
					nxt_state.running = 1'b1;
					nxt_state.cnt     = '0;
				end else begin
					nxt_state.cnt = state_ff.cnt + 1'b1;
				end
			end
		endcase
		// option owns the pin: array sees zero, otherwise the pad level
		nxt_state.arrayDownIn = powerDownEn ? 1'b0
			: pinIn[`PDC_DOWN_MC]; // R1 R7
		if (frozen)
			nxt_state.arrayDownIn = state_ff.arrayDownIn; // R5
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			state_ff <= '{mode: PDC_ACTIVE, cnt: '0, lowPower: 1'b0,
				running: 1'b1, arrayDownIn: 1'b0};
		else if (clkEn)
			state_ff <= nxt_state;
	end

	pdc_input_keeper u_keeper (
		.clk         (clk),
		.rst         (rst),
		.clkEn       (clkEn),
		.block       (frozen),
		.maskDownPin (powerDownEn),
		.pinIn       (pinIn),
		.keptIn      (arrayIn)
	);

	pdc_macrocell_bank u_bank (
		.clk            (clk),
		.rst            (rst),
		.clkEn          (clkEn),
		.freeze         (frozen),
		.downPinIsInput (powerDownEn),
		.term           (term),
		.feedback       (feedback),
		.pad            (pad)
	);

	assign arrayDownIn = state_ff.arrayDownIn;
	assign lowPower    = state_ff.lowPower;
	assign running     = state_ff.running;

endmodule : pdc_power_down_ctrl

// ---- test/pdc_pd_driver.sv ----
// partner model: system logic that drives the power-down pin
// assumes the bench settles its other inputs before it raises req
`timescale 1ns/100ps

module pdc_pd_driver (
	input  wire logic	clk,
	input  wire logic	rst,
	input  wire logic	req,
	output logic		powerDownPin
);
	// a whole cycle of settled inputs before the rise, more than the setup
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			powerDownPin <= 1'h0;
		end else begin
			powerDownPin <= #1 req;
		end
	end
endmodule : pdc_pd_driver

// ---- test/pdc_power_down_ctrl_props.sv ----
// checker of the power-down block, bound to its top module
// assumes one clock domain and clkEn held high while freezing
`timescale 1ns/100ps

module pdc_power_down_ctrl_props import pdc_pkg::*; (
	input wire logic		clk,
	input wire logic		rst,
	input wire logic		clkEn,
	input wire logic		powerDownEn,
	input wire logic		powerDownPin,
	input wire pdc_word_type	pinIn,
	input wire pdc_array_type	term,
	input wire pdc_word_type	arrayIn,
	input wire pdc_word_type	feedback,
	input wire pdc_pad_type		pad,
	input wire logic		arrayDownIn,
	input wire logic		lowPower,
	input wire logic		running
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence enter_s;
		!running ##1 lowPower;
	endsequence
	sequence held_s;
		lowPower && $past(lowPower);
	endsequence
	enter_freeze_a: assert property (clkEn && powerDownEn && powerDownPin
		&& running |=> enter_s) else $error("no freeze");
	hold_outputs_a: assert property (held_s
		|-> $stable(feedback) && $stable(pad.data)) else $error("state moved");
	hold_hiz_a: assert property (held_s |-> $stable(pad.oe))
		else $error("enable moved");
	block_down_a: assert property (held_s |-> $stable(arrayDownIn))
		else $error("array pin input moved");
	keep_pins_a: assert property (held_s |-> $stable(arrayIn))
		else $error("pin moved");
	down_not_array_a: assert property (powerDownEn
		&& $past(powerDownEn) && $past(clkEn) |-> !arrayDownIn && !arrayIn[2])
		else $error("shared pin fed array");
	option_off_a: assert property (!powerDownEn && !$past(powerDownEn)
		&& $past(clkEn) |-> !lowPower) else $error("froze without option");
	plain_input_a: assert property (!powerDownEn && !$past(powerDownEn)
		&& $past(clkEn) && !$past(lowPower)
		|-> arrayDownIn == $past(pinIn[2])) else $error("pin not plain input");
	down_feedback_a: assert property (running && !lowPower && clkEn
		&& term.regEn[2] |=> feedback[2] == $past(term.d[2]))
		else $error("shared cell feedback");
	resume_bound_a: assert property ($fell(lowPower) |-> ##[1:25] running)
		else $error("slow resume");
	reopen_in_a: assert property ($fell(lowPower) && clkEn
		|=> (arrayIn & 32'hFFFF_FFFB) == ($past(pinIn) & 32'hFFFF_FFFB))
		else $error("inputs shut");
	resume_held_a: assert property ($fell(lowPower) && clkEn
		&& !term.regEn[1] |=> feedback[1] == $past(feedback[1]))
		else $error("state reset");
endmodule : pdc_power_down_ctrl_props

bind pdc_power_down_ctrl pdc_power_down_ctrl_props chk (.clk, .rst, .clkEn,
	.powerDownEn, .powerDownPin, .pinIn, .term, .arrayIn, .feedback, .pad,
	.arrayDownIn, .lowPower, .running);

// ---- test/tb_pdc_power_down_ctrl.sv ----
// bench of the power-down block with a pin-driving partner
// assumes the bound checker; inputs move 1 ns after the rising edge
`timescale 1ns/100ps

module tb_pdc_power_down_ctrl import pdc_pkg::*;;
	logic		clk = 0, rst = 1, clkEn = 1, powerDownEn = 1, req = 0;
	logic		powerDownPin, arrayDownIn, lowPower, running;
	pdc_word_type	pinIn = '0, arrayIn, feedback, fbHeld, inHeld;
	pdc_array_type	term = '0;
	pdc_pad_type	pad, padHeld;
	int		fails = 0, checksDone = 0;

	initial forever #20 clk = ~clk;
	pdc_pd_driver drv (.clk, .rst, .req, .powerDownPin);
	pdc_power_down_ctrl dut (.clk, .rst, .clkEn, .powerDownEn, .powerDownPin,
		.pinIn, .term, .arrayIn, .feedback, .pad, .arrayDownIn, .lowPower,
		.running);

	task chk(input bit ok, input string m);
		checksDone++;
		if (!ok) begin
			$display("MISMATCH %0t %s", $time, m);
			fails++;
		end
	endtask : chk
	task tally_and_finish;
		if (fails == 0 && checksDone > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	// bounded wait; running out ends the run
	task automatic wt(ref logic s, input logic v);
		int n = 0;
		while (s !== v && n < 40) begin
			cyc(1);
			n++;
		end
		if (s !== v) begin
			chk(0, "timeout");
			tally_and_finish;
		end
	endtask : wt

	task t_active;
		pinIn = 32'hFFFF_FFFF;
		term.d = 32'hA5A5_5A5A;
		term.regEn = 32'hFFFF_FFFF;
		term.oe = 32'h0000_FFFF;
		cyc(2);
		chk(arrayIn === 32'hFFFF_FFFB, "shared pad reached array");
		chk(arrayDownIn === 1'h0, "array pin input");
		chk(feedback === 32'hA5A5_5A5A, "feedback");
		chk(pad.data === 32'hA5A5_5A5A, "output data");
		chk(pad.oe === 32'h0000_FFFB, "shared pin driven");
	endtask : t_active

	task t_freeze;
		req = 1;
		wt(lowPower, 1);
		cyc(2);
		fbHeld = feedback;
		padHeld = pad;
		inHeld = arrayIn;
		pinIn = 32'h1234_5678;
		term.d = 32'h0F0F_0F0F;
		term.oe = 32'hFFFF_FFFF;
		term.regEn = 32'hFFFF_0000;
		cyc(3);
		chk(feedback === fbHeld && pad.data === padHeld.data, "moved");
		chk(pad.oe === padHeld.oe, "hi-z lost");
		chk(arrayIn === inHeld, "inputs leaked");
		req = 0;
		wt(lowPower, 0);
		chk(feedback === fbHeld, "state lost");
		wt(running, 1);
		chk(arrayIn === 32'h1234_5678, "inputs shut");
		chk(feedback === 32'h0F0F_5A5A, "no resume");
		chk(pad.data === 32'h0F0F_5A5A, "output not resumed");
		chk(pad.oe === 32'hFFFF_FFFB, "enables shut");
	endtask : t_freeze

	task t_off;
		powerDownEn = 0;
		pinIn[2] = 1;
		req = 1;
		cyc(4);
		chk(lowPower === 1'h0 && arrayDownIn === 1'h1, "option off");
		chk(arrayIn[2] === 1'h1, "shared pad not plain");
		req = 0;
		cyc(2);
		powerDownEn = 1;
		cyc(2);
	endtask : t_off

	// combinational select: data from terms, register left alone
	task t_comb;
		term.d = 32'h5555_AAAA;
		term.comSel = 32'h00FF_00FF;
		term.regEn = 32'h0000_0000;
		cyc(2);
		chk(feedback === 32'h0F0F_5A5A, "register moved");
		chk(pad.data === 32'h0F55_5AAA, "comb output");
	endtask : t_comb

	initial begin
		cyc(10);
		rst = 0;
		cyc(1);
		t_active;
		t_freeze;
		t_off;
		t_comb;
		tally_and_finish;
	end
endmodule : tb_pdc_power_down_ctrl
